/* include/dpdc_pkg.sv */
package dpdc_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG0 = 8'h04;
  localparam logic [7:0] REG_CFG1 = 8'h08;
  localparam logic [7:0] REG_CNT0 = 8'h0c;
  localparam logic [7:0] REG_CNT1 = 8'h10;
  localparam logic [7:0] REG_TMODE = 8'h14;
  localparam logic [7:0] REG_SMR = 8'h18;
  localparam logic [7:0] REG_STAT = 8'h1c;
  localparam logic [7:0] REG_MASK = 8'h20;
  // control register: one nibble per counter
  localparam int CTL_EN = 0;
  localparam int CTL_LOAD = 1;
  localparam int CTL_CONT = 2;
  localparam int CTL_STRIDE = 4;
  // clock mode register fields
  localparam int SMR_DIV16 = 0;
  localparam int SMR_FULL = 1;
  localparam logic [7:0] SMR_RST = 8'h00;
  localparam int SLOW_DIV = 16;
  localparam int INT_DIV = 4;
  // interrupt request bits
  localparam int IRQ_N = 6;
  localparam int IRQ_T0 = 4;
  localparam int IRQ_T1 = 5;
  localparam int MASK_GLOBAL = 7;
  localparam int CFG_W = 14;
  localparam int TMODE_W = 6;
  localparam int STAT_W = 6;
  localparam int MASK_W = 8;
  localparam int SMR_W = 8;

  typedef enum logic [1:0] {
    SRC_INT = 2'h0,
    SRC_EXT = 2'h1,
    SRC_CASC = 2'h2,
    SRC_RSVD = 2'h3
  } dpdc_src_e;

  typedef enum logic [1:0] {
    TIN_CLK = 2'h0,
    TIN_GATE = 2'h1,
    TIN_TRIG = 2'h2,
    TIN_RETRIG = 2'h3
  } dpdc_tin_e;

  typedef enum logic [1:0] {
    TIMER_OUTPUT_PIN_OFF = 2'h0,
    TIMER_OUTPUT_PIN_T0 = 2'h1,
    TIMER_OUTPUT_PIN_T1 = 2'h2,
    TIMER_OUTPUT_PIN_INT = 2'h3
  } dpdc_timer_output_pin_e;

  // per-counter setup: reload in [7:0], prescale ratio in [13:8]
  typedef struct packed {
    logic [5:0] presc;
    logic [7:0] reload;
  } dpdc_tcfg_s;

  // timer mode: source [1:0], input pin use [3:2], output select [5:4]
  typedef struct packed {
    dpdc_timer_output_pin_e timer_output_pin;
    dpdc_tin_e timer_input_pin;
    dpdc_src_e src;
  } dpdc_tmode_s;
endpackage

/* hdl/dpdc_timer.sv */
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
// Overview of operation
// - two 8-bit counters, each behind its own 6-bit prescaler
// - counter zero prescaler uses internal clock; counter one may use external clock
// - each prescaler divides its source by any ratio 1 to 64
// - counters decrement per prescaler tick; end of count raises own request
// - software can start, stop, continue, or restart from the load value
// - single pass halts at zero; continuous mode reloads and keeps counting
// - counts readable anytime without disturbing them; prescalers not readable
// - counter one clock: internal clock divided by four, or input pin
// - input pin acts as clock, trigger, retrigger, or gate on internal clock
// - output pin carries counter zero, counter one, or internal clock
// - counter zero end of count can drive counter one input
// - clock mode bit zero inserts divide by sixteen on timer clock
// - clock mode bit one clear halves clock, set gives full rate
// - mask enables six requests individually plus a global enable
module dpdc_timer
  import dpdc_pkg::*;
#(
  parameter int NTMR = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_port_req,
  input wire logic i_timer_input_pin,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  output logic o_timer_output_pin
);

  // address match, shared by read mux and write strobes
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  // ---------------- APB slave ----------------
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] rd_data;
  wire setup = i_psel & ~i_penable;
  wire wr_en = i_psel & i_penable & pready_ff & i_pwrite;
  wire hit_ctrl = reg_hit(i_paddr, REG_CTRL);
  wire hit_cfg0 = reg_hit(i_paddr, REG_CFG0);
  wire hit_cfg1 = reg_hit(i_paddr, REG_CFG1);
  wire hit_cnt0 = reg_hit(i_paddr, REG_CNT0);
  wire hit_cnt1 = reg_hit(i_paddr, REG_CNT1);
  wire hit_tmode = reg_hit(i_paddr, REG_TMODE);
  wire hit_smr = reg_hit(i_paddr, REG_SMR);
  wire hit_stat = reg_hit(i_paddr, REG_STAT);
  wire hit_mask = reg_hit(i_paddr, REG_MASK);
  wire hit_any = hit_ctrl | hit_cfg0 | hit_cfg1 | hit_cnt0 | hit_cnt1 | hit_tmode
               | hit_smr | hit_stat | hit_mask;
  wire wr_ctrl = wr_en & hit_ctrl;

  // no wait state: data is sampled in setup so prdata can be a flop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~hit_any;
      if (setup) begin
        prdata_ff <= rd_data;
      end
    end
  end

  // ---------------- configuration registers ----------------
  dpdc_tcfg_s cfg_ff [NTMR];
  dpdc_tmode_s tmode_ff;
  logic [SMR_W-1:0] smr_ff;
  logic [MASK_W-1:0] mask_ff;
  logic [MASK_W-1:0] nxt_mask;
  logic [NTMR-1:0] cont_ff;
  assign nxt_mask = (wr_en & hit_mask) ? i_pwdata[MASK_W-1:0] : mask_ff;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tmode_ff <= dpdc_tmode_s'(6'h00);
      smr_ff <= SMR_RST;
      mask_ff <= 8'h00;
    end else begin
      if (wr_en & hit_tmode) begin
        tmode_ff <= dpdc_tmode_s'(i_pwdata[TMODE_W-1:0]);
      end
      if (wr_en & hit_smr) begin
        smr_ff <= i_pwdata[SMR_W-1:0];
      end
      mask_ff <= nxt_mask;
    end
  end

  // ---------------- timer clock ----------------
  logic half_ff;
  logic [3:0] slow_cnt_ff;
  logic [1:0] int_cnt_ff;
  // half rate unless full rate selected
  wire timer_clock_line_pre = smr_ff[SMR_FULL] | half_ff;
  // optional divide by sixteen for power saving
  wire timer_clock_line_en = smr_ff[SMR_DIV16] ? (timer_clock_line_pre & (slow_cnt_ff == 4'(SLOW_DIV - 1))) : timer_clock_line_pre;
  // internal timer clock is the timer clock line divided by four
  wire int_tick = timer_clock_line_en & (int_cnt_ff == 2'(INT_DIV - 1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      half_ff <= 1'b0;
      slow_cnt_ff <= 4'h0;
      int_cnt_ff <= 2'h0;
    end else begin
      half_ff <= ~half_ff;
      if (timer_clock_line_pre) begin
        slow_cnt_ff <= slow_cnt_ff + 4'h1;
      end
      if (timer_clock_line_en) begin
        int_cnt_ff <= int_cnt_ff + 2'h1;
      end
    end
  end

  // ---------------- input pin sampling ----------------
  // three stages; level accepted only when stages two and three agree
  logic [2:0] tin_s_ff;
  logic tin_lvl_ff;
  wire tin_agree = (tin_s_ff[1] == tin_s_ff[2]);
  // edges ride on the filtered level, so pulses under two clocks are lost
  wire tin_rise = tin_agree & tin_s_ff[2] & ~tin_lvl_ff;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tin_s_ff <= 3'h0;
      tin_lvl_ff <= 1'b0;
    end else begin
      tin_s_ff <= {tin_s_ff[1:0], i_timer_input_pin};
      if (tin_agree) begin
        tin_lvl_ff <= tin_s_ff[2];
      end
    end
  end

  // ---------------- counter sources ----------------
  logic [NTMR-1:0] src_tick;
  logic [NTMR-1:0] trig_start;
  logic [NTMR-1:0] eoc;
  logic [NTMR-1:0] ptick;
  logic [NTMR-1:0] run_ff;
  logic [7:0] count_ff [NTMR];
  logic [5:0] presc_cnt_ff [NTMR];
  logic [NTMR-1:0] tog_ff;
  wire t1_int = (tmode_ff.src == SRC_INT);
  wire t1_trig_mode = (tmode_ff.timer_input_pin == TIN_TRIG) | (tmode_ff.timer_input_pin == TIN_RETRIG);
  // gate qualifies the internal clock with the pin level
  wire t1_int_tick = (tmode_ff.timer_input_pin == TIN_GATE) ? (int_tick & tin_lvl_ff) : int_tick;

  // counter zero internal only, counter one selectable
  assign src_tick[0] = int_tick;
  // cascade takes counter zero end of count as counter one clock
  assign src_tick[1] = (tmode_ff.src == SRC_EXT) ? tin_rise
                     : (tmode_ff.src == SRC_CASC) ? eoc[0]
                     : t1_int & t1_int_tick;
  // a non-retriggerable trigger is ignored while counter one runs
  assign trig_start[0] = 1'b0;
  assign trig_start[1] = t1_int & t1_trig_mode & tin_rise
                       & ((tmode_ff.timer_input_pin == TIN_RETRIG) | ~run_ff[1]);

  // ---------------- counters ----------------
  genvar gi;
  generate
    for (gi = 0; gi < NTMR; gi++) begin : g_tmr
      wire sw_load = wr_ctrl & i_pwdata[gi*CTL_STRIDE + CTL_LOAD];
      // a load wins over a tick in the same cycle, so a restart keeps its reload
      wire load = sw_load | trig_start[gi];
      wire presc_wrap = (presc_cnt_ff[gi] == 6'h00);
      // field value 0 stands for 64, so ratio minus one wraps to 63
      wire [5:0] presc_top = cfg_ff[gi].presc - 6'h01;
      logic [7:0] nxt_count;
      // each counter has its own prescaler
      assign ptick[gi] = src_tick[gi] & run_ff[gi] & presc_wrap & ~load;
      // end of count on the tick that leaves one
      assign eoc[gi] = ptick[gi] & (count_ff[gi] == 8'h01);
      // reload in continuous mode, park at zero in single pass
      assign nxt_count = load ? cfg_ff[gi].reload
                       : ~ptick[gi] ? count_ff[gi]
                       : ~eoc[gi] ? count_ff[gi] - 8'h01
                       : cont_ff[gi] ? cfg_ff[gi].reload : 8'h00;

      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          presc_cnt_ff[gi] <= 6'h00;
          count_ff[gi] <= 8'h00;
          tog_ff[gi] <= 1'b0;
        end else begin
          if (load) begin
            presc_cnt_ff[gi] <= presc_top;
          end else if (src_tick[gi] & run_ff[gi]) begin
            presc_cnt_ff[gi] <= presc_wrap ? presc_top : presc_cnt_ff[gi] - 6'h01;
          end
          count_ff[gi] <= nxt_count;
          if (eoc[gi]) begin
            tog_ff[gi] <= ~tog_ff[gi];
          end
        end
      end

      // enable bit starts or stops; write wins over the hardware stop
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          run_ff[gi] <= 1'b0;
          cont_ff[gi] <= 1'b0;
          cfg_ff[gi] <= dpdc_tcfg_s'(14'h0000);
        end else begin
          if (wr_ctrl) begin
            run_ff[gi] <= i_pwdata[gi*CTL_STRIDE + CTL_EN];
            cont_ff[gi] <= i_pwdata[gi*CTL_STRIDE + CTL_CONT];
          end else if (trig_start[gi]) begin
            run_ff[gi] <= 1'b1;
          // single pass end drops the count enable
          end else if (eoc[gi] & ~cont_ff[gi]) begin
            run_ff[gi] <= 1'b0;
          end
          if (wr_en & (gi == 0 ? hit_cfg0 : hit_cfg1)) begin
            cfg_ff[gi] <= dpdc_tcfg_s'(i_pwdata[CFG_W-1:0]);
          end
        end
      end
    end
  endgenerate

  // ---------------- interrupts and output pin ----------------
  logic [STAT_W-1:0] stat_ff;
  logic [STAT_W-1:0] nxt_stat;
  logic irq_ff;
  logic int_tog_ff;
  logic timer_output_pin_ff;
  logic nxt_timer_output_pin;
  wire [STAT_W-1:0] w1c = (wr_en & hit_stat) ? i_pwdata[STAT_W-1:0] : 6'h00;
  // requests from both counters next to the port requests
  wire [STAT_W-1:0] events = {eoc[1], eoc[0], i_port_req};
  // a new event beats a clear in the same cycle
  assign nxt_stat = (stat_ff & ~w1c) | events;
  assign nxt_timer_output_pin = (tmode_ff.timer_output_pin == TIMER_OUTPUT_PIN_T0) ? tog_ff[0]
                  : (tmode_ff.timer_output_pin == TIMER_OUTPUT_PIN_T1) ? tog_ff[1]
                  : (tmode_ff.timer_output_pin == TIMER_OUTPUT_PIN_INT) ? int_tog_ff : 1'b0;

  // individual mask bits gated by the global enable
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_ff <= 6'h00;
      irq_ff <= 1'b0;
      int_tog_ff <= 1'b0;
      timer_output_pin_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_ff <= nxt_mask[MASK_GLOBAL] & (|(nxt_stat & nxt_mask[STAT_W-1:0]));
      int_tog_ff <= int_tog_ff ^ int_tick;
      timer_output_pin_ff <= nxt_timer_output_pin;
    end
  end

  // counts read straight from the counters; prescalers have no address
  assign rd_data = hit_ctrl ? {25'h0, cont_ff[1], 1'b0, run_ff[1], 1'b0, cont_ff[0], 1'b0,
                               run_ff[0]}
                 : hit_cfg0 ? {18'h0, cfg_ff[0]}
                 : hit_cfg1 ? {18'h0, cfg_ff[1]}
                 : hit_cnt0 ? {24'h0, count_ff[0]}
                 : hit_cnt1 ? {24'h0, count_ff[1]}
                 : hit_tmode ? {26'h0, tmode_ff}
                 : hit_smr ? {24'h0, smr_ff}
                 : hit_stat ? {26'h0, stat_ff}
                 : hit_mask ? {24'h0, mask_ff} : 32'h0;

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_irq = irq_ff;
  assign o_timer_output_pin = timer_output_pin_ff;

  // ---------------- assertions ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // single pass end of count for counter zero, and the state it must leave behind
  sequence s_eoc0_single;
    eoc[0] & ~cont_ff[0] & ~wr_ctrl;
  endsequence
  sequence s_t0_parked;
    ~run_ff[0] & (count_ff[0] == 8'h00);
  endsequence

  a_single_halt: assert property (s_eoc0_single |=> s_t0_parked)
    else $error("single pass counter did not park at zero");
  a_cont_reload: assert property (eoc[0] & cont_ff[0] & ~wr_ctrl |=>
    count_ff[0] == $past(cfg_ff[0].reload))
    else $error("continuous counter did not reload");
  a_count_step: assert property (ptick[1] & ~eoc[1] |=>
    count_ff[1] == $past(count_ff[1]) - 8'h01)
    else $error("counter did not step down by one");
  a_count_hold: assert property (~ptick[0] & ~g_tmr[0].load |=> $stable(count_ff[0]))
    else $error("counter moved without a tick");
  a_presc_wrap: assert property (src_tick[0] & run_ff[0] & presc_cnt_ff[0] == 6'h00
    & ~g_tmr[0].load |=> presc_cnt_ff[0] == $past(cfg_ff[0].presc) - 6'h01)
    else $error("prescaler did not restart at ratio minus one");
  a_t1_request: assert property (eoc[1] |=> stat_ff[IRQ_T1] ##1 stat_ff[IRQ_T1]
    || $past(w1c[IRQ_T1]))
    else $error("counter one request not raised");
  a_irq_gate: assert property (o_irq == (mask_ff[MASK_GLOBAL]
    & (|(stat_ff & mask_ff[STAT_W-1:0]))))
    else $error("interrupt output disagrees with status and mask");
  a_tin_filter: assert property ($changed(tin_lvl_ff) |-> $past(tin_agree))
    else $error("pin level accepted before stages agreed");
  a_cascade_tick: assert property (tmode_ff.src == SRC_CASC & eoc[0] & run_ff[1]
    & presc_cnt_ff[1] == 6'h00 & ~g_tmr[1].load |-> ptick[1])
    else $error("cascade did not clock counter one");
  a_trig_start: assert property (trig_start[1] & ~wr_ctrl |=>
    run_ff[1] & count_ff[1] == $past(cfg_ff[1].reload))
    else $error("trigger did not start counter one");
  a_timer_output_pin_sel: assert property (tmode_ff.timer_output_pin == TIMER_OUTPUT_PIN_T0 ##1 $stable(tmode_ff.timer_output_pin)
    |-> o_timer_output_pin == $past(tog_ff[0]))
    else $error("output pin not following counter zero");
  a_full_rate: assert property (smr_ff[SMR_FULL] & ~smr_ff[SMR_DIV16] |-> timer_clock_line_en)
    else $error("full rate clock enable missing");
  // a read shows the count of its setup cycle and leaves the counter alone
  a_read_count: assert property (setup & hit_cnt0 |=>
    o_prdata == {24'h0, $past(count_ff[0])})
    else $error("count read back differs from counter");
  // a pending request survives until software writes a one to it
  a_stat_sticky: assert property (stat_ff[IRQ_T0] & ~w1c[IRQ_T0] |=> stat_ff[IRQ_T0])
    else $error("timer request dropped without a clear");
  // a plain trigger must not restart a running counter
  a_trig_ignore: assert property (tmode_ff.timer_input_pin == TIN_TRIG & run_ff[1] |-> ~trig_start[1])
    else $error("non-retriggerable trigger restarted counter one");

endmodule

/* bench/dpdc_pin_src.sv */
`timescale 1ns/10ps
// far-side source on the timer input pin; idles low between bursts
module dpdc_pin_src (
  input wire logic i_clk,
  output logic o_pin
);
  initial o_pin = 1'h0;
  // slow pulses so the pin synchroniser sees every level
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      repeat (w) @(posedge i_clk);
      o_pin <= 1'h1;
      repeat (w) @(posedge i_clk);
      o_pin <= 1'h0;
    end
  endtask
  task automatic level(input logic v);
    @(posedge i_clk);
    o_pin <= v;
  endtask
endmodule

/* bench/dual_prescaled_down_counter_test.sv */
`timescale 1ns/10ps
// register, timing and pin checks of the two counters
module dual_prescaled_down_counter_test;
  import dpdc_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic er;
  } dpdc_row_s;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic i_psel = 1'h0;
  logic i_penable = 1'h0;
  logic i_pwrite = 1'h0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [3:0] i_port_req = 4'h0;
  logic pin, pready, pslverr, irq, timer_output_pin, err;
  logic [1:0] gs;
  logic [31:0] prdata, rd, x;
  int mismatches = 0;
  int samples_checked = 0;
  int t, k, p, r;
  // writes then reads back; unmapped and read-only places included
  dpdc_row_s rows[8] = '{'{REG_CFG0, 32'hffffffff, 32'h3fff, 1'h0},
    '{REG_CFG1, 32'hffffffff, 32'h3fff, 1'h0}, '{REG_TMODE, 32'h3f, 32'h3f, 1'h0},
    '{REG_SMR, 32'h3, 32'h3, 1'h0}, '{REG_MASK, 32'hbf, 32'hbf, 1'h0},
    '{REG_CNT0, 32'hff, 32'h0, 1'h0}, '{REG_STAT, 32'h3f, 32'h0, 1'h0},
    '{8'h24, 32'hffffffff, 32'h0, 1'h1}};
  // clock mode, prescale and reload packed as smr/presc/reload
  logic [31:0] tm[6] = '{32'h20103, 32'h00103, 32'h30102, 32'h20002, 32'h20100, 32'h10101};
  // output select with the toggle window it should give
  logic [31:0] to[4] = '{32'h00000, 32'h11215, 32'h20000, 32'h3262a};

  always #10 i_clk = ~i_clk;

  dpdc_timer u_dut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_port_req(i_port_req),
    .i_timer_input_pin(pin),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .o_irq(irq),
    .o_timer_output_pin(timer_output_pin)
  );
  dpdc_pin_src u_src (
    .i_clk(i_clk),
    .o_pin(pin)
  );

  task automatic final_report();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1'h1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'h1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      if (n > 20) begin
        chk("pready", 1, pready);
        final_report();
      end
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wait_irq(input int mx);
    t = 0;
    while (irq !== 1'h1) begin
      @(posedge i_clk);
      t++;
      if (t > mx) begin
        chk("irq_wait", 1, irq);
        final_report();
      end
    end
  endtask
  task automatic tog(input int n);
    logic l;
    k = 0;
    l = timer_output_pin;
    repeat (n) begin
      @(posedge i_clk);
      if (timer_output_pin !== l)
        k++;
      l = timer_output_pin;
    end
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'h0;
    for (k = 0; k < 9; k++) begin
      rdr(8'(4 * k));
      chk("reset", 0, rd);
    end
    foreach (rows[i]) begin
      w(rows[i].a, rows[i].d);
      chk("werr", rows[i].er, err);
      rdr(rows[i].a);
      chk("rdata", rows[i].e, rd);
    end
    w(REG_TMODE, 32'h0);
    // single pass timing under every clock mode, boundary counts too
    foreach (tm[i]) begin
      x = tm[i];
      p = (x[13:8] == 0 ? 64 : x[13:8]) * INT_DIV * (x[17] ? 1 : 2) * (x[16] ? SLOW_DIV : 1);
      r = x[7:0] == 0 ? 256 : x[7:0];
      w(REG_SMR, {24'h0, x[23:16]});
      w(REG_CFG0, {18'h0, x[13:0]});
      w(REG_MASK, 32'h90);
      w(REG_STAT, 32'h30);
      w(REG_CTRL, 32'h3);
      wait_irq(r * p + 40);
      chk("t_lo", 1, t >= (r - 1) * p - 2);
      chk("t_hi", 1, t <= r * p + 8);
      rdr(REG_CNT0);
      chk("cnt0", 0, rd);
      rdr(REG_CTRL);
      chk("run0", 0, rd[0]);
      rdr(REG_STAT);
      chk("stat", 32'h10, rd);
      w(REG_STAT, 32'h10);
      cyc(2);
      chk("irq_clr", 0, irq);
    end
    // other request sources: individual and global enables
    for (k = 0; k < 4; k++) begin
      x = 32'h1 << k;
      w(REG_MASK, x);
      @(posedge i_clk);
      i_port_req <= x[3:0];
      @(posedge i_clk);
      i_port_req <= 4'h0;
      cyc(2);
      chk("irq_g", 0, irq);
      rdr(REG_STAT);
      chk("stat_p", x, rd);
      w(REG_MASK, 32'hbf ^ x);
      cyc(2);
      chk("irq_m", 0, irq);
      w(REG_MASK, 32'h80 | x);
      cyc(2);
      chk("irq_u", 1, irq);
      w(REG_STAT, x);
      cyc(2);
      chk("irq_c", 0, irq);
    end
    // continuous reload, then stop, continue and restart
    w(REG_SMR, 32'h2);
    w(REG_MASK, 32'h90);
    w(REG_CFG0, 32'h102);
    w(REG_CTRL, 32'h7);
    wait_irq(60);
    w(REG_STAT, 32'h10);
    wait_irq(20);
    chk("reload", 1, t <= 10);
    rdr(REG_CTRL);
    chk("run_c", 32'h5, rd);
    w(REG_CFG0, 32'h8c8);
    w(REG_CTRL, 32'h3);
    cyc(10);
    w(REG_CTRL, 32'h0);
    rdr(REG_CNT0);
    x = rd;
    cyc(100);
    rdr(REG_CNT0);
    chk("stop", x, rd);
    w(REG_CTRL, 32'h1);
    cyc(100);
    rdr(REG_CNT0);
    chk("cont", 1, (x - rd) inside {[2:4]});
    w(REG_CTRL, 32'h3);
    rdr(REG_CNT0);
    chk("restart", 1, rd >= 32'hc7);
    // counter one on pin edges only
    w(REG_CTRL, 32'h0);
    w(REG_TMODE, 32'h1);
    w(REG_CFG1, 32'h103);
    w(REG_MASK, 32'ha0);
    w(REG_STAT, 32'h3f);
    w(REG_CTRL, 32'h30);
    u_src.pulses(2, 6);
    cyc(8);
    rdr(REG_STAT);
    chk("ext2", 0, rd);
    u_src.pulses(1, 6);
    cyc(8);
    rdr(REG_STAT);
    chk("ext3", 32'h20, rd);
    // plain trigger ends in burst, retrigger keeps reloading
    w(REG_CFG1, 32'h105);
    for (k = 0; k < 2; k++) begin
      w(REG_CTRL, 32'h0);
      w(REG_TMODE, k ? 32'hc : 32'h8);
      w(REG_STAT, 32'h20);
      cyc(30);
      rdr(REG_STAT);
      chk("idle", 0, rd);
      u_src.pulses(6, 4);
      rdr(REG_STAT);
      chk("trig", k ? 32'h0 : 32'h20, rd);
      wait_irq(40);
    end
    // gate: one pin level counts, the other holds
    w(REG_TMODE, 32'h4);
    w(REG_CFG1, 32'h1c8);
    w(REG_CTRL, 32'h30);
    for (k = 0; k < 2; k++) begin
      u_src.level(k[0]);
      cyc(6);
      rdr(REG_CNT1);
      x = rd;
      cyc(40);
      rdr(REG_CNT1);
      gs[k] = (x === rd);
    end
    chk("gate", 32'h1, {30'h0, gs});
    w(REG_CTRL, 32'h0);
    w(REG_CFG0, 32'h102);
    w(REG_CTRL, 32'h7);
    foreach (to[i]) begin
      x = to[i];
      w(REG_TMODE, {26'h0, x[17:16], 4'h0});
      cyc(4);
      tog(160);
      chk("tog_lo", 1, k >= x[15:8]);
      chk("tog_hi", 1, k <= x[7:0]);
    end
    // cascade: counter one steps on counter zero ends
    w(REG_TMODE, 32'h2);
    w(REG_CFG0, 32'h103);
    w(REG_CFG1, 32'h103);
    w(REG_STAT, 32'h3f);
    w(REG_CTRL, 32'h77);
    wait_irq(80);
    chk("casc", 1, t >= 24);
    rdr(REG_CTRL);
    chk("ctl_c", 32'h55, rd);
    @(posedge i_clk);
    i_rst <= 1'h1;
    cyc(2);
    i_rst <= 1'h0;
    chk("rst_irq", 0, irq);
    rdr(REG_CTRL);
    chk("rst_ctl", 0, rd);
    final_report();
  end
endmodule
